// ==== tsio_port.sv ====
`timescale 1ns/10ps
// Functional notes
// - direction bit 1 drives pin, 0 leaves it input
// - output latch bits 4..0 drive pins set as outputs
// - data read returns latch where direction bit is 1
// - data read returns pin level where direction bit is 0
// - pin 4 timer output for channel d codes 001 and 01x
// - pin 3 timer output for channel c codes 001 and 01x
// - pin 2 timer output for channel b codes 001 and 01x
// - pin 1 timer output for channel a codes 001 and 01x
// - pin 0 always feeds timer clock; direction bit 0 only
// - input-only port reads four pin levels, read-only
// - analog-selected input-only pins read as zero
// - timer claim overrides port direction and data
module tsio_port
  import tsio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] pinIn,
  output logic [4:0] pinOut,
  output logic [4:0] pinOe,
  input wire logic [3:0] timerOut,
  output logic [3:0] timerChanIn,
  output logic timerClkIn,
  input wire logic [3:0] inbPinIn
);
  typedef struct packed {
    logic [4:0] dirReg;
    logic [4:0] dataReg;
    logic [2:0] modeA;
    logic [2:0] modeB;
    logic [2:0] modeC;
    logic [2:0] modeD;
    logic [3:0] anSel;
    logic [31:0] rdata;
    logic [4:0] pinOut;
    logic [4:0] pinOe;
    logic [3:0] chanIn;
    logic clkIn;
    logic ready;
  } tsio_state_t;

  tsio_state_t st_reg;
  tsio_state_t st_next;
  logic wrEn;
  logic rdEn;
  logic [5:0] hit;
  logic [3:0] muxOe;
  logic [3:0] muxOut;
  logic [3:0] owns;
  logic [11:0] modes;

  tsio_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .wrEn(wrEn),
    .rdEn(rdEn),
    .hit(hit)
  );

  assign modes = {st_reg.modeD, st_reg.modeC, st_reg.modeB, st_reg.modeA};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      tsio_pin_mux u_mux (
        .modeField(modes[g*3 +: 3]),
        .dirBit(st_reg.dirReg[g+1]),
        .dataBit(st_reg.dataReg[g+1]),
        .timerOut(timerOut[g]),
        .pinOe(muxOe[g]),
        .pinOut(muxOut[g]),
        .timerOwns(owns[g])
      );
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    // pslverr path: unmapped reads answer zero, no error
    if (wrEn) begin
      if (hit[0]) begin
        st_next.dirReg = pwdata[TSIO_PORT_N-1:0];
      end
      if (hit[1]) begin
        st_next.dataReg = pwdata[TSIO_PORT_N-1:0];
      end
      if (hit[3]) begin
        st_next.modeA = pwdata[TSIO_MODE_LO +: TSIO_MODE_W];
        st_next.modeB = pwdata[TSIO_MODE_HI +: TSIO_MODE_W];
      end
      if (hit[4]) begin
        st_next.modeC = pwdata[TSIO_MODE_LO +: TSIO_MODE_W];
        st_next.modeD = pwdata[TSIO_MODE_HI +: TSIO_MODE_W];
      end
      if (hit[5]) begin
        st_next.anSel = pwdata[TSIO_INB_N-1:0];
      end
    end
    if (rdEn) begin
      st_next.rdata = '0;
      // direction register is write-only, reads zero
      if (hit[1]) begin
        st_next.rdata[TSIO_PORT_N-1:0] =
          (st_reg.dirReg & st_reg.dataReg) | (~st_reg.dirReg & pinIn);
      end
      if (hit[2]) begin
        st_next.rdata[TSIO_INB_N-1:0] = inbPinIn & ~st_reg.anSel;
      end
      if (hit[3]) begin
        st_next.rdata[TSIO_MODE_LO +: TSIO_MODE_W] = st_reg.modeA;
        st_next.rdata[TSIO_MODE_HI +: TSIO_MODE_W] = st_reg.modeB;
      end
      if (hit[4]) begin
        st_next.rdata[TSIO_MODE_LO +: TSIO_MODE_W] = st_reg.modeC;
        st_next.rdata[TSIO_MODE_HI +: TSIO_MODE_W] = st_reg.modeD;
      end
      if (hit[5]) begin
        st_next.rdata[TSIO_INB_N-1:0] = st_reg.anSel;
      end
    end
    st_next.pinOe[0] = st_reg.dirReg[0];
    st_next.pinOut[0] = st_reg.dirReg[0] & st_reg.dataReg[0];
    st_next.pinOe[4:1] = muxOe;
    st_next.pinOut[4:1] = muxOut & muxOe;
    // timer inputs always follow pins, even when driving
    st_next.chanIn = pinIn[4:1];
    st_next.clkIn = pinIn[0];
    // zero-wait slave: ready from first edge after reset
    st_next.ready = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.dirReg <= TSIO_DIR_RST;
      st_reg.dataReg <= TSIO_DATA_RST;
      st_reg.anSel <= TSIO_ANSEL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = 1'b0;
  assign pinOut = st_reg.pinOut;
  assign pinOe = st_reg.pinOe;
  assign timerChanIn = st_reg.chanIn;
  assign timerClkIn = st_reg.clkIn;
endmodule

// ==== tsio_pkg.sv ====
package tsio_pkg;
  localparam int TSIO_DATA_W = 32;
  localparam int TSIO_PORT_N = 5;
  localparam int TSIO_INB_N = 4;
  localparam int TSIO_MODE_W = 3;
  // byte addresses on the register bus
  localparam logic [11:0] TSIO_OFF_DIR = 12'h000;
  localparam logic [11:0] TSIO_OFF_DATA = 12'h004;
  localparam logic [11:0] TSIO_OFF_INB = 12'h008;
  localparam logic [11:0] TSIO_OFF_TMRAB = 12'h00c;
  localparam logic [11:0] TSIO_OFF_TMRCD = 12'h010;
  localparam logic [11:0] TSIO_OFF_ANSEL = 12'h014;
  localparam logic [4:0] TSIO_DIR_RST = 5'h00;
  localparam logic [4:0] TSIO_DATA_RST = 5'h00;
  localparam logic [2:0] TSIO_MODE_RST = 3'h0;
  localparam logic [3:0] TSIO_ANSEL_RST = 4'h0;
  // field layout of the timer mode registers: low and high channel
  localparam int TSIO_MODE_LO = 0;
  localparam int TSIO_MODE_HI = 4;
  localparam int TSIO_MODE_TOP = 2;
endpackage

// ==== tsio_pin_mux.sv ====
`timescale 1ns/10ps
module tsio_pin_mux
  import tsio_pkg::*;
(
  input wire logic [2:0] modeField,
  input wire logic dirBit,
  input wire logic dataBit,
  input wire logic timerOut,
  output logic pinOe,
  output logic pinOut,
  output logic timerOwns
);
  // timer output for codes 001 and 01x, top bit clear
  always_comb begin
    timerOwns = !modeField[TSIO_MODE_TOP] && (modeField != TSIO_MODE_RST);
    pinOe = timerOwns ? 1'b1 : dirBit;
    pinOut = timerOwns ? timerOut : dataBit;
  end
endmodule

// ==== tsio_apb_slave.sv ====
`timescale 1ns/10ps
module tsio_apb_slave
  import tsio_pkg::*;
(
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  output logic wrEn,
  output logic rdEn,
  output logic [5:0] hit
);
  localparam logic [11:0] OFFS [6] = '{TSIO_OFF_DIR, TSIO_OFF_DATA,
    TSIO_OFF_INB, TSIO_OFF_TMRAB, TSIO_OFF_TMRCD, TSIO_OFF_ANSEL};
  // writes in access phase, reads in setup phase; zero wait states
  always_comb begin
    wrEn = psel && penable && pwrite;
    rdEn = psel && !penable && !pwrite;
    for (int i = 0; i < 6; i++) begin
      hit[i] = (paddr == OFFS[i]);
    end
  end
endmodule

// ==== tsio_pins_model.sv ====
`timescale 1ns/10ps
module tsio_pins_model(
  input wire logic [4:0] pinOut,
  input wire logic [4:0] pinOe,
  input wire logic [4:0] ext,
  output logic [4:0] pinIn
);
  // released pins fall back to the board level, never a stale drive
  assign pinIn = (pinOut & pinOe) | (ext & ~pinOe);
endmodule

// ==== tsio_port_checker.sv ====
`timescale 1ns/10ps
module tsio_port_checker
  import tsio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] pinIn,
  input wire logic [4:0] pinOut,
  input wire logic [4:0] pinOe,
  input wire logic [3:0] timerChanIn,
  input wire logic timerClkIn,
  input wire logic [3:0] inbPinIn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire rd = psel && !penable && !pwrite;
  // first edge after a release still shows reset values
  property p_rdy; $past(rst_b) |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; !pslverr; endproperty
  a_err: assert property (p_err) else $error("error response");
  property p_off; (pinOut & ~pinOe) == 5'h00; endproperty
  a_off: assert property (p_off) else $error("undriven pin high");
  property p_sync;
    $past(rst_b) |-> {timerChanIn, timerClkIn} == $past(pinIn);
  endproperty
  a_sync: assert property (p_sync) else $error("timer input lost");
  property p_dwo;
    rd && paddr == TSIO_OFF_DIR |=> prdata == 32'h0;
  endproperty
  a_dwo: assert property (p_dwo) else $error("direction readable");
  property p_rsv;
    rd && paddr == TSIO_OFF_DATA |=> prdata[31:5] == 27'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_inb;
    rd && paddr == TSIO_OFF_INB |=> prdata[31:4] == 28'h0 &&
      (prdata[3:0] & ~$past(inbPinIn)) == 4'h0;
  endproperty
  a_inb: assert property (p_inb) else $error("input port bad");
  property p_unm;
    rd && paddr > TSIO_OFF_ANSEL |=> prdata == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
endmodule
bind tsio_port tsio_port_checker i_chk(.*);

// ==== tsio_port_test.sv ====
`timescale 1ns/10ps
module tsio_port_test;
  import tsio_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, timerClkIn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] pinIn, pinOut, pinOe, ext;
  logic [3:0] timerOut, timerChanIn, inbPinIn;
  int err_total, cmp_count, dir, dat, mab, mcd, an, own, oe, po, pe;
  tsio_port i_dut(.*);
  tsio_pins_model i_pins(.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // held until pready seen high; psel stays up for back to back
  task automatic ap(input logic w, input logic [11:0] a, input int d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
  endtask
  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict;
  end
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext, timerOut, inbPinIn} = 13'h0ad6;
    void'($urandom(32'h841c));
    repeat (10) @(posedge clk);
    chk(32'(pinOe), 32'h0);
    rst_b <= 1'b1;
    @(posedge clk);
    ap(1'b0, TSIO_OFF_DATA, 0);
    chk(q, 32'(ext));
    // channel a walks all eight mode codes
    for (int i = 0; i < 24; i++) begin
      dir = $urandom;
      dat = $urandom;
      mab = $urandom & ~7 | i % 8;
      mcd = $urandom;
      an = $urandom;
      ext <= 5'($urandom);
      timerOut <= 4'($urandom);
      inbPinIn <= 4'($urandom);
      ap(1'b1, TSIO_OFF_DIR, dir);
      ap(1'b1, TSIO_OFF_DATA, dat);
      ap(1'b1, TSIO_OFF_TMRAB, mab);
      ap(1'b1, TSIO_OFF_TMRCD, mcd);
      ap(1'b1, TSIO_OFF_ANSEL, an);
      ap(1'b1, TSIO_OFF_INB, 32'hffffffff);
      idle(3);
      own = 0;
      for (int k = 0; k < 4; k++) begin
        pe = (k < 2 ? mab : mcd) >> (k % 2 * 4) & 7;
        if (pe > 0 && pe < 4)
          own |= 2 << k;
      end
      oe = (dir | own) & 31;
      po = (dat & dir & ~own | timerOut * 2 & own) & 31;
      pe = po | ext & ~oe;
      chk(32'(pinOe), oe & 31);
      chk(32'(pinOut), po);
      chk(32'({timerChanIn, timerClkIn}), pe & 31);
      ap(1'b0, TSIO_OFF_DATA, 0);
      chk(q, (dat & dir | pe & ~dir) & 31);
      ap(1'b0, TSIO_OFF_INB, 0);
      chk(q, inbPinIn & ~an & 15);
      ap(1'b0, 12'h018, 0);
      chk(q, 32'h0);
      idle(1);
    end
    // second reset mid-run: pins back to input, latch cleared
    rst_b <= 1'b0;
    idle(2);
    chk(32'(pinOe), 32'h0);
    rst_b <= 1'b1;
    idle(2);
    ap(1'b0, TSIO_OFF_DATA, 0);
    chk(q, 32'(ext));
    ap(1'b1, TSIO_OFF_DIR, 32'h0000001f);
    ap(1'b0, TSIO_OFF_DATA, 0);
    chk(q, 32'h0);
    ap(1'b0, TSIO_OFF_DIR, 0);
    chk(q, 32'h0);
    idle(1);
    print_verdict;
  end
endmodule
